// >>> wake_bus_status_pkg.sv
// Purpose: Constants and carriers for the wake and bus status register bank
// Assumes: 16-bit serial frame {clear, address[6:0], data[7:0]}, MSB first
// Notes:   Core clock 20 MHz; serial link runs on its own clock
package wake_bus_status_pkg;

    localparam logic [6:0] ADDR_LEVEL      = 7'h48;
    localparam logic [6:0] ADDR_WAKE_TWO   = 7'h49;
    localparam logic [6:0] ADDR_BUS_TWO    = 7'h4a;

    localparam int LVL_DEV_BIT     = 7;
    localparam int LVL_CFG_BIT     = 6;
    localparam int LVL_FOCFG_BIT   = 5;
    localparam int LVL_SUPPLY_BIT  = 4;
    localparam int LVL_UVLIVE_BIT  = 3;
    localparam int LVL_WAKE_BIT    = 0;
    localparam int WK2_UVLATCH_BIT = 7;
    localparam int WK2_CH1_BIT     = 0;
    localparam int NIB_TO_BIT      = 3;
    localparam int NIB_SE_BIT      = 2;
    localparam int NIB_FAIL_LSB    = 0;
    localparam int CH2_NIB_LSB     = 4;

    localparam logic [7:0] WAKE_TWO_RESET = 8'h00;
    localparam logic [7:0] BUS_TWO_RESET  = 8'h00;

    localparam logic [1:0] FAIL_NONE    = 2'h0;
    localparam logic [1:0] FAIL_TSD     = 2'h1;
    localparam logic [1:0] FAIL_TXD_DOM = 2'h2;
    localparam logic [1:0] FAIL_BUS_DOM = 2'h3;

    localparam logic [5:0] SWK_ERR_LIMIT = 6'h20;

    localparam int CLK_PERIOD_NS  = 50;
    localparam int TX_EN_TIME_NS  = 8000;
    localparam int TX_EN_CYCLES   = (TX_EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int FRAME_BITS   = 16;
    localparam int FRM_CLR_BIT  = 15;
    localparam int FRM_ADDR_LSB = 8;

    typedef struct packed {
        logic       clear;
        logic [6:0] addr;
        logic [7:0] mask;
    } host_frame_s;

    typedef struct packed {
        logic       selwake_enable;
        logic       bus_silence;
        logic       selwake_cfg_error;
        logic [5:0] selwake_err_count;
        logic       thermal_shutdown;
        logic       transmit_dominant_timeout;
        logic       bus_dominant_timeout;
        logic       tx_off;
        logic       wake_capable;
        logic       bus_recessive;
        logic       supply_uv;
    } chan_in_s;

    typedef struct packed {
        logic       timeout_flag;
        logic       selwake_sys_error;
        logic [1:0] fail;
        logic       tx_enable;
        logic       timeout_set;
    } chan_out_s;

endpackage

// >>> chan_status.sv
// Purpose: Per-channel timeout, system error, failure field and transmit gate
// Assumes: All inputs on core_clk; txd_high already synchronised
// Notes:   Set always wins over a host clear in the same cycle
`timescale 1ns/10ps
module chan_status
    import wake_bus_status_pkg::*;
(
    input  wire logic      core_clk,
    input  wire logic      sys_rst,
    input  wire logic      soft_rst,
    input  wire chan_in_s  ci,
    input  wire logic      txd_high,
    input  wire logic      int_fall,
    input  wire logic      clr_to,
    input  wire logic      clr_se,
    input  wire logic      clr_fail,
    output chan_out_s      co
);
    logic        silence_d_reg;
    logic        clr_lock_reg;
    logic        txd_fault_reg;
    logic        bus_fault_reg;
    logic [15:0] ten_cnt_reg;
    logic        to_set;
    logic        se_set;
    logic        fault_any;
    logic [1:0]  fail_code;

    assign to_set = ci.selwake_enable & ci.bus_silence & ~silence_d_reg;
    assign se_set = ci.selwake_enable &
                    (ci.selwake_cfg_error | (ci.selwake_err_count > SWK_ERR_LIMIT));

    always_comb begin
        if (ci.bus_dominant_timeout) begin
            fail_code = FAIL_BUS_DOM;
        end else if (ci.transmit_dominant_timeout) begin
            fail_code = FAIL_TXD_DOM;
        end else if (ci.thermal_shutdown) begin
            fail_code = FAIL_TSD;
        end else begin
            fail_code = FAIL_NONE;
        end
    end

    assign fault_any = txd_fault_reg | bus_fault_reg | ci.thermal_shutdown | ci.supply_uv;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            silence_d_reg <= 1'b0;
        end else begin
            silence_d_reg <= ci.bus_silence;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clr_lock_reg <= 1'b0;
        end else if (soft_rst) begin
            clr_lock_reg <= 1'b0;
        end else if (to_set) begin
            clr_lock_reg <= 1'b1;
        end else if (int_fall) begin
            clr_lock_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            co.timeout_flag <= 1'b0;
            co.timeout_set  <= 1'b0;
        end else begin
            co.timeout_set <= to_set;
            if (soft_rst) begin
                co.timeout_flag <= 1'b0;
            end else if (to_set) begin
                co.timeout_flag <= 1'b1;
            end else if (clr_to && !clr_lock_reg) begin
                co.timeout_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            co.selwake_sys_error <= 1'b0;
        end else if (soft_rst) begin
            co.selwake_sys_error <= 1'b0;
        end else if (se_set) begin
            co.selwake_sys_error <= 1'b1;
        end else if (clr_se) begin
            co.selwake_sys_error <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            co.fail <= FAIL_NONE;
        end else if (soft_rst) begin
            co.fail <= FAIL_NONE;
        end else if (fail_code != FAIL_NONE) begin
            co.fail <= fail_code;
        end else if (clr_fail) begin
            co.fail <= FAIL_NONE;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txd_fault_reg <= 1'b0;
        end else if (ci.transmit_dominant_timeout) begin
            txd_fault_reg <= 1'b1;
        end else if (txd_high || ci.tx_off || ci.wake_capable) begin
            txd_fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_fault_reg <= 1'b0;
        end else if (ci.bus_dominant_timeout) begin
            bus_fault_reg <= 1'b1;
        end else if (ci.bus_recessive || ci.wake_capable || ci.tx_off) begin
            bus_fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ten_cnt_reg  <= 16'h0000;
            co.tx_enable <= 1'b0;
        end else if (fault_any) begin
            ten_cnt_reg  <= 16'h0000;
            co.tx_enable <= 1'b0;
        end else if (!co.tx_enable) begin
            if (!txd_high) begin
                ten_cnt_reg <= 16'h0000;
            end else if (ten_cnt_reg == 16'(TX_EN_CYCLES - 1)) begin
                co.tx_enable <= 1'b1;
            end else begin
                ten_cnt_reg <= ten_cnt_reg + 16'h0001;
            end
        end
    end

endmodule

// >>> wake_and_bus_status_regs.sv
// Purpose: Wake level, wake source and channel 1/2 bus status registers
// Assumes: Serial link clocked by serial_clk, frames framed by serial_cs_n
// Notes:   Read data returned in the frame after the one that addressed it
`timescale 1ns/10ps
module wake_and_bus_status_regs
    import wake_bus_status_pkg::*;
#(
    parameter int CHAN_N = 2
) (
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             soft_rst,
    input  wire logic             serial_clk,
    input  wire logic             serial_cs_n,
    input  wire logic             serial_mosi,
    output logic                  serial_miso,
    output logic                  serial_miso_oe,
    input  wire logic             dev_mode_pin,
    input  wire logic             interrupt_pin,
    input  wire logic             supply_cfg_pin,
    input  wire logic             battery_sense_input,
    input  wire logic             wake_input_level,
    input  wire logic [2:1]       chan_transmit_input,
    input  wire logic             fail_output_cfg_bit,
    input  wire logic [3:1]       chan_wake_evt,
    input  wire logic [3:1]       failsafe_exit_wake_evt,
    input  wire logic             mode_stop_or_normal,
    input  wire logic [2:1]       timeout_irq_mask,
    input  wire chan_in_s [2:1]   chan_in,
    output logic                  wd_reset_inhibit,
    output logic                  timeout_irq,
    output logic [2:1]            chan_tx_enable
);
    localparam int PIN_N = 8;

    // Register layout has room for exactly two channels
    if (CHAN_N != 2) begin : g_chan_check
        $error("Only two channels share this bus status register");
    end

    // Link domain
    logic [FRAME_BITS-1:0] shift_reg;
    logic [4:0]            bit_cnt_reg;
    host_frame_s           frame_reg;
    logic                  frame_tgl_reg;
    logic [3:0]            out_idx_reg;
    logic                  miso_reg;

    // Core domain
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] pin_s1_reg;
    logic [PIN_N-1:0] pin_s2_reg;
    logic [2:0]       tgl_sync_reg;
    logic             int_d_reg;
    logic             cfg_level_reg;
    logic [1:0]       cfg_cap_cnt_reg;
    logic             uv_latched_reg;
    logic [3:1]       wake_flag_reg;
    logic [7:0]       read_data_reg;
    logic             miso_oe_reg;
    logic             irq_reg;
    logic             wd_inh_reg;
    host_frame_s      cmd;
    logic             cmd_valid;
    logic             int_fall;
    logic [7:0]       level_word;
    logic [7:0]       wake_two_word;
    logic [7:0]       bus_two_word;
    logic [7:0]       clr_wake_two;
    logic [7:0]       clr_bus_two;
    logic [7:0]       read_mux;
    chan_out_s [2:1]  chan_out;

    // Serial shift-in; counter cleared whenever the frame select is idle
    always_ff @(posedge serial_clk or posedge serial_cs_n) begin
        if (serial_cs_n) begin
            bit_cnt_reg <= 5'h00;
        end else if (bit_cnt_reg != 5'(FRAME_BITS)) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge serial_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_reg <= 16'h0000;
        end else begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], serial_mosi};
        end
    end

    // Word held stable until the next full frame, flagged by toggle
    always_ff @(posedge serial_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_reg     <= '0;
            frame_tgl_reg <= 1'b0;
        end else if (!serial_cs_n && bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
            frame_reg     <= host_frame_s'({shift_reg[FRAME_BITS-2:0], serial_mosi});
            frame_tgl_reg <= ~frame_tgl_reg;
        end
    end

    // Read data out on falling edges; first bit is a fixed zero
    always_ff @(negedge serial_clk or posedge serial_cs_n) begin
        if (serial_cs_n) begin
            out_idx_reg <= 4'h0;
            miso_reg    <= 1'b0;
        end else begin
            if (out_idx_reg != 4'hf) begin
                out_idx_reg <= out_idx_reg + 4'h1;
            end
            if (out_idx_reg < 4'h8) begin
                miso_reg <= read_data_reg[3'(4'h7 - out_idx_reg)];
            end else begin
                miso_reg <= 1'b0;
            end
        end
    end

    assign serial_miso = miso_reg;

    // Pin synchronisers, two flops each
    assign pin_raw = {serial_cs_n, chan_transmit_input, wake_input_level,
                      battery_sense_input, supply_cfg_pin, interrupt_pin, dev_mode_pin};

    genvar gp;
    generate
        for (gp = 0; gp < PIN_N; gp++) begin : g_sync
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    // Frame select rests high, so the data line stays off after reset
                    pin_s1_reg[gp] <= (gp == PIN_N - 1);
                    pin_s2_reg[gp] <= (gp == PIN_N - 1);
                end else begin
                    pin_s1_reg[gp] <= pin_raw[gp];
                    pin_s2_reg[gp] <= pin_s1_reg[gp];
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tgl_sync_reg <= 3'h0;
            int_d_reg    <= 1'b0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], frame_tgl_reg};
            int_d_reg    <= pin_s2_reg[1];
        end
    end

    assign cmd_valid = tgl_sync_reg[2] ^ tgl_sync_reg[1];
    assign cmd       = frame_reg;
    assign int_fall  = int_d_reg & ~pin_s2_reg[1];

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_cap_cnt_reg <= 2'h0;
            cfg_level_reg   <= 1'b0;
        end else if (cfg_cap_cnt_reg != 2'h3) begin
            cfg_cap_cnt_reg <= cfg_cap_cnt_reg + 2'h1;
            if (cfg_cap_cnt_reg == 2'h2) begin
                cfg_level_reg <= pin_s2_reg[1];
            end
        end
    end

    // Host clear masks, only from a clear frame
    assign clr_wake_two = (cmd_valid && cmd.clear && cmd.addr == ADDR_WAKE_TWO) ?
                          cmd.mask : 8'h00;
    assign clr_bus_two  = (cmd_valid && cmd.clear && cmd.addr == ADDR_BUS_TWO) ?
                          cmd.mask : 8'h00;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            uv_latched_reg <= WAKE_TWO_RESET[WK2_UVLATCH_BIT];
        end else if (soft_rst) begin
            uv_latched_reg <= WAKE_TWO_RESET[WK2_UVLATCH_BIT];
        end else if (pin_s2_reg[3]) begin
            uv_latched_reg <= 1'b1;
        end else if (clr_wake_two[WK2_UVLATCH_BIT]) begin
            uv_latched_reg <= 1'b0;
        end
    end

    genvar gw;
    generate
        for (gw = 1; gw <= 3; gw++) begin : g_wake
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    wake_flag_reg[gw] <= WAKE_TWO_RESET[WK2_CH1_BIT + gw - 1];
                end else if (soft_rst) begin
                    wake_flag_reg[gw] <= WAKE_TWO_RESET[WK2_CH1_BIT + gw - 1];
                end else if (chan_wake_evt[gw] || failsafe_exit_wake_evt[gw]) begin
                    wake_flag_reg[gw] <= 1'b1;
                end else if (clr_wake_two[WK2_CH1_BIT + gw - 1]) begin
                    wake_flag_reg[gw] <= 1'b0;
                end
            end
        end
    endgenerate

    genvar gc;
    generate
        for (gc = 1; gc <= CHAN_N; gc++) begin : g_chan
            chan_status u_chan (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .soft_rst (soft_rst),
                .ci       (chan_in[gc]),
                .txd_high (pin_s2_reg[4 + gc]),
                .int_fall (int_fall),
                .clr_to   (clr_bus_two[(gc - 1) * CH2_NIB_LSB + NIB_TO_BIT]),
                .clr_se   (clr_bus_two[(gc - 1) * CH2_NIB_LSB + NIB_SE_BIT]),
                .clr_fail (|clr_bus_two[(gc - 1) * CH2_NIB_LSB + NIB_FAIL_LSB +: 2]),
                .co       (chan_out[gc])
            );
        end
    endgenerate

    always_comb begin
        level_word                 = 8'h00;
        level_word[LVL_DEV_BIT]    = pin_s2_reg[0];
        level_word[LVL_CFG_BIT]    = cfg_level_reg;
        level_word[LVL_FOCFG_BIT]  = fail_output_cfg_bit;
        level_word[LVL_SUPPLY_BIT] = pin_s2_reg[2];
        level_word[LVL_UVLIVE_BIT] = pin_s2_reg[3];
        level_word[LVL_WAKE_BIT]   = pin_s2_reg[4];
    end

    always_comb begin
        wake_two_word                             = 8'h00;
        wake_two_word[WK2_UVLATCH_BIT]            = uv_latched_reg;
        wake_two_word[WK2_CH1_BIT +: 3]           = wake_flag_reg;
    end

    always_comb begin
        bus_two_word = 8'h00;
        for (int c = 1; c <= 2; c++) begin
            bus_two_word[(c - 1) * CH2_NIB_LSB + NIB_TO_BIT]        = chan_out[c].timeout_flag;
            bus_two_word[(c - 1) * CH2_NIB_LSB + NIB_SE_BIT]        = chan_out[c].selwake_sys_error;
            bus_two_word[(c - 1) * CH2_NIB_LSB + NIB_FAIL_LSB +: 2] = chan_out[c].fail;
        end
    end

    always_comb begin
        case (cmd.addr)
            ADDR_LEVEL:    read_mux = level_word;
            ADDR_WAKE_TWO: read_mux = wake_two_word;
            ADDR_BUS_TWO:  read_mux = bus_two_word;
            default:       read_mux = 8'h00;
        endcase
    end

    // Snapshot after the clear so the next frame sees the cleared value
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            read_data_reg <= 8'h00;
        end else if (pin_s2_reg[7]) begin
            read_data_reg <= read_mux;
        end
    end

    // Drive the data line only while the frame select is active
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            miso_oe_reg <= 1'b0;
        end else begin
            miso_oe_reg <= ~pin_s2_reg[7];
        end
    end

    assign serial_miso_oe = miso_oe_reg;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= mode_stop_or_normal &
                       |({chan_out[2].timeout_set, chan_out[1].timeout_set} & ~timeout_irq_mask);
        end
    end

    assign timeout_irq = irq_reg;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wd_inh_reg <= 1'b0;
        end else begin
            wd_inh_reg <= pin_s2_reg[0];
        end
    end

    assign wd_reset_inhibit = wd_inh_reg;

    always_comb begin
        for (int c = 1; c <= 2; c++) begin
            chan_tx_enable[c] = chan_out[c].tx_enable;
        end
    end

endmodule

// >>> serial_host.sv
// Purpose: Serial host model standing at the far side of the status bank
// Assumes: Link clock stands still outside frames
// Notes:   Read data of a frame belongs to the address of the frame before
`timescale 1ns/10ps
module serial_host (
    output logic      serial_clk,
    output logic      serial_cs_n,
    output logic      serial_mosi,
    input  wire logic serial_miso
);
    initial serial_clk = 1'b0;
    initial serial_cs_n = 1'b1;
    initial serial_mosi = 1'b0;
    task automatic xfer(input logic [15:0] w, output logic [7:0] d);
        #7 serial_cs_n = 1'b0;
        for (int k = 15; k >= 0; k--) begin
            serial_mosi = w[k];
            #15 serial_clk = 1'b1;
            if (k inside {[7:14]}) d[k-7] = serial_miso;
            #15 serial_clk = 1'b0;
        end
        #15 serial_cs_n = 1'b1;
        // Idle line shows the inverse so a stale bit cannot pass
        serial_mosi = ~serial_mosi;
        #300;
    endtask
endmodule

// >>> wake_and_bus_status_regs_asserts.sv
// Purpose: Port assertions for the wake and bus status bank
// Assumes: Input synchronisers add at most three core cycles
// Notes:   Transmit gate timing watched on channel 1, bus dominant drop on channel 2, to stay small
`timescale 1ns/10ps
module wake_bus_status_checker
    import wake_bus_status_pkg::*;
#(
    parameter int CHAN_N = 2
) (
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire logic           serial_cs_n,
    input  wire logic           serial_miso_oe,
    input  wire logic           dev_mode_pin,
    input  wire logic           wd_reset_inhibit,
    input  wire logic           mode_stop_or_normal,
    input  wire logic [2:1]     timeout_irq_mask,
    input  wire logic           timeout_irq,
    input  wire logic [2:1]     chan_transmit_input,
    input  wire chan_in_s [2:1] chan_in,
    input  wire logic [2:1]     chan_tx_enable
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Saturating run of high samples, so long idle stretches cannot wrap
    logic [8:0] txd_run_reg;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txd_run_reg <= 9'h000;
        end else if (!chan_transmit_input[1]) begin
            txd_run_reg <= 9'h000;
        end else if (txd_run_reg != 9'h1ff) begin
            txd_run_reg <= txd_run_reg + 9'h001;
        end
    end
    chk_dev_on: assert property (dev_mode_pin [*5] |-> wd_reset_inhibit)
        else $error("inhibit low with pin high");
    chk_dev_off: assert property (!dev_mode_pin [*5] |-> !wd_reset_inhibit)
        else $error("inhibit high with pin low");
    chk_irq_mode: assert property (!mode_stop_or_normal [*4] |-> !timeout_irq)
        else $error("timeout irq outside stop or normal");
    chk_irq_masked: assert property ((timeout_irq_mask == 2'b11) [*4] |-> !timeout_irq)
        else $error("masked timeout irq");
    chk_tsd_drop: assert property (chan_in[1].thermal_shutdown |-> ##[1:3] !chan_tx_enable[1])
        else $error("transmit kept in thermal shutdown");
    chk_busdom_drop: assert property (chan_in[2].bus_dominant_timeout |-> ##[1:3] !chan_tx_enable[2])
        else $error("transmit kept on bus dominant");
    chk_uv_drop: assert property (chan_in[1].supply_uv |-> ##[1:3] !chan_tx_enable[1])
        else $error("transmit kept in supply undervoltage");
    chk_tx_wait: assert property ($rose(chan_tx_enable[1]) |-> txd_run_reg >= TX_EN_CYCLES)
        else $error("transmit enabled too early");
    chk_oe_idle: assert property (serial_cs_n [*4] |-> !serial_miso_oe)
        else $error("data line driven outside a frame");
    chk_oe_drive: assert property (!serial_cs_n [*4] |-> serial_miso_oe)
        else $error("data line not driven in a frame");
    cover property ($rose(timeout_irq));
    cover property ($rose(chan_tx_enable[2]));
    cover property ($fell(wd_reset_inhibit));
endmodule

bind wake_and_bus_status_regs wake_bus_status_checker #(.CHAN_N(CHAN_N))
    u_wake_bus_status_checker (.core_clk, .sys_rst, .serial_cs_n, .serial_miso_oe,
    .dev_mode_pin, .wd_reset_inhibit, .mode_stop_or_normal, .timeout_irq_mask, .timeout_irq,
    .chan_transmit_input, .chan_in, .chan_tx_enable);

// >>> test_wake_and_bus_status_regs.sv
// Purpose: Self-checking bench for the wake and bus status bank
// Assumes: Serial host model issues every register access
// Notes:   A read costs two frames since data returns one frame late
`timescale 1ns/10ps
module test_wake_and_bus_status_regs;
    import wake_bus_status_pkg::*;
    logic           core_clk, sys_rst, soft_rst, serial_clk, serial_cs_n, serial_mosi;
    logic           serial_miso, serial_miso_oe, dev_mode_pin, interrupt_pin, supply_cfg_pin;
    logic           battery_sense_input, wake_input_level, fail_output_cfg_bit;
    logic           mode_stop_or_normal, wd_reset_inhibit, timeout_irq;
    logic [2:1]     chan_transmit_input, timeout_irq_mask, chan_tx_enable;
    logic [3:1]     chan_wake_evt, failsafe_exit_wake_evt;
    chan_in_s [2:1] chan_in;
    int             num_errors, checks_done, irq_cnt;

    wake_and_bus_status_regs u_wake_and_bus_status_regs (.core_clk, .sys_rst, .soft_rst,
        .serial_clk, .serial_cs_n, .serial_mosi, .serial_miso, .serial_miso_oe, .dev_mode_pin,
        .interrupt_pin, .supply_cfg_pin, .battery_sense_input, .wake_input_level,
        .chan_transmit_input, .fail_output_cfg_bit, .chan_wake_evt, .failsafe_exit_wake_evt,
        .mode_stop_or_normal, .timeout_irq_mask, .chan_in, .wd_reset_inhibit, .timeout_irq,
        .chan_tx_enable);
    serial_host u_serial_host (.serial_clk, .serial_cs_n, .serial_mosi, .serial_miso);

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) irq_cnt += int'(timeout_irq === 1'b1);

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_serial_host.xfer({1'b0, a, 8'h00}, d);
        u_serial_host.xfer(16'h0000, d);
        check(d, exp);
    endtask
    task automatic clr(input logic [6:0] a, input logic [7:0] m);
        logic [7:0] d;
        u_serial_host.xfer({1'b1, a, m}, d);
    endtask

    task automatic t_levels;
        rd_reg(ADDR_WAKE_TWO, WAKE_TWO_RESET);
        rd_reg(ADDR_BUS_TWO, BUS_TWO_RESET);
        rd_reg(ADDR_LEVEL, 8'hd1);
        cyc(1);
        {dev_mode_pin, interrupt_pin, supply_cfg_pin, battery_sense_input} = 4'b0001;
        {wake_input_level, fail_output_cfg_bit} = 2'b01;
        cyc(6);
        check({7'h00, wd_reset_inhibit}, 8'h00);
        rd_reg(ADDR_LEVEL, 8'h68);
        rd_reg(7'h00, 8'h00);
        $display("levels done");
    endtask
    task automatic t_wake;
        cyc(1);
        battery_sense_input = 1'b0;
        {chan_wake_evt, failsafe_exit_wake_evt} = 6'b101010;
        cyc(1);
        {chan_wake_evt, failsafe_exit_wake_evt} = 6'h00;
        cyc(4);
        rd_reg(ADDR_WAKE_TWO, 8'h87);
        clr(ADDR_WAKE_TWO, 8'h05);
        clr(ADDR_LEVEL, 8'hff);
        rd_reg(ADDR_WAKE_TWO, 8'h82);
        rd_reg(ADDR_LEVEL, 8'h60);
        cyc(1);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        rd_reg(ADDR_WAKE_TWO, 8'h00);
        $display("wake done");
    endtask
    task automatic t_fail;
        for (int c = 1; c <= 3; c++) begin
            cyc(1);
            // Thermal, transmit dominant and bus dominant flags in turn
            chan_in[1][6:4] = 3'b100 >> (c - 1);
            cyc(2);
            check({7'h00, chan_tx_enable[1]}, 8'h00);
            chan_in[1][6:4] = 3'b000;
            rd_reg(ADDR_BUS_TWO, 8'(c));
            clr(ADDR_BUS_TWO, 8'h03);
        end
        cyc(1);
        chan_transmit_input = 2'b00;
        {chan_in[2].bus_dominant_timeout, chan_in[2].bus_recessive} = 2'b10;
        chan_in[1].supply_uv = 1'b1;
        cyc(3);
        check({6'h00, chan_tx_enable}, 8'h00);
        {chan_in[2].bus_dominant_timeout, chan_in[2].bus_recessive} = 2'b01;
        chan_in[1].supply_uv = 1'b0;
        cyc(20);
        chan_transmit_input = 2'b11;
        cyc(150);
        check({6'h00, chan_tx_enable}, 8'h00);
        cyc(30);
        check({6'h00, chan_tx_enable}, 8'h03);
        rd_reg(ADDR_BUS_TWO, 8'h30);
        clr(ADDR_BUS_TWO, 8'hff);
        $display("fail done");
    endtask
    task automatic t_timeout;
        cyc(1);
        {mode_stop_or_normal, timeout_irq_mask} = 3'b110;
        chan_in[1].selwake_err_count = 6'h20;
        {chan_in[1].selwake_enable, chan_in[2].selwake_enable} = 2'b11;
        cyc(2);
        {chan_in[1].bus_silence, chan_in[2].bus_silence} = 2'b11;
        cyc(5);
        check(8'(irq_cnt), 8'h01);
        {chan_in[1].bus_silence, chan_in[2].bus_silence} = 2'b00;
        interrupt_pin = 1'b1;
        cyc(5);
        clr(ADDR_BUS_TWO, 8'hff);
        rd_reg(ADDR_BUS_TWO, 8'h88);
        cyc(1);
        interrupt_pin = 1'b0;
        chan_in[1].selwake_err_count = 6'h21;
        {chan_in[2].selwake_enable, chan_in[2].selwake_cfg_error} = 2'b01;
        cyc(5);
        clr(ADDR_BUS_TWO, 8'h88);
        rd_reg(ADDR_BUS_TWO, 8'h04);
        timeout_irq_mask = 2'b11;
        chan_in[1].bus_silence = 1'b1;
        cyc(5);
        check(8'(irq_cnt), 8'h01);
        $display("timeout done");
    endtask

    initial begin
        {sys_rst, soft_rst, mode_stop_or_normal, timeout_irq_mask} = 5'b10011;
        {dev_mode_pin, interrupt_pin, supply_cfg_pin, battery_sense_input} = 4'b1110;
        {wake_input_level, fail_output_cfg_bit, chan_transmit_input} = 4'b1011;
        {chan_wake_evt, failsafe_exit_wake_evt} = 6'h00;
        chan_in = '0;
        {chan_in[1].bus_recessive, chan_in[2].bus_recessive} = 2'b11;
        repeat (10) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        cyc(6);
        t_levels();
        t_wake();
        t_fail();
        t_timeout();
        report_and_stop();
    end
    // Run needs about 45 us; over five times that marks a hang
    initial begin
        #240000;
        num_errors++;
        report_and_stop();
    end
endmodule
